// file: design/mode_irq_pkg.sv
// shared constants and types for the mode strap / external interrupt block
// assumes a single core clock and a synchronous active-low reset
package mode_irq_pkg;

    localparam int          NUM_LINES      = 4;      // mode_select_a..d share pins with interrupt lines
    localparam int          MODE_W         = 4;      // four pins pick one of sixteen modes
    localparam int          SYNC_STAGES    = 2;      // flops in every input synchroniser
    localparam logic [3:0]  MODE_RST       = 4'h0;   // not loaded anywhere; operating_mode_reg has no reset and takes the pins from the first clock
    localparam logic [3:0]  PEND_RST       = 4'h0;   // no pending edge requests after reset
    localparam logic [3:0]  REQ_RST        = 4'h0;   // no requests shown after reset
    localparam logic [3:0]  PIN_IDLE       = 4'hf;   // deasserted level of active-low pins
    localparam logic        RUN_RST        = 1'b0;   // core held in reset

    // per-line trigger setup, driven by the core's own control logic
    typedef struct packed {
        logic [3:0] enable;    // 1 = line may request
        logic [3:0] edgeSel;   // 1 = negative edge, 0 = low level
    } int_cfg_s;

endpackage

// file: design/mode_latch_ext_irq.sv
// mode strap capture and external interrupt request front end
// assumes the core drives trigger setup, acknowledges edge requests and flags its wait state
// Behaviour
// [RULE1] Each mode/interrupt pin is active low and passes a clocked synchroniser before use.
// [RULE2] While reset is held the four pins are sampled and their value is kept as the operating mode at release.
// [RULE3] After reset each pin is a maskable request, level or negative-edge triggered.
// [RULE4] A request on any enabled pin ends the core's wait state.
// [RULE5] For lock-step restart the source asserts its request synchronous to the clock during wait.
// [RULE6] Release of reset is synchronised to the clock and marks mode capture and start of requests.
// [RULE7] Each line has a level/edge select and an enable, and edge requests stay pending until serviced.
`timescale 1ns/10ps
module mode_latch_ext_irq
    import mode_irq_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // shared mode / interrupt pins, active low, index 0 = line a
    input  wire logic [LINES-1:0]   modeIntPin_n,
    // core control
    input  wire int_cfg_s           intCfg,
    input  wire logic [LINES-1:0]   serviceAck,
    input  wire logic               coreInWait,
    // results
    output logic      [MODE_W-1:0]  operatingModeReg,
    output logic      [LINES-1:0]   intReq,
    output logic                    waitWake,
    output logic                    coreRun
);

    initial begin
        if (LINES != NUM_LINES) $error("mode capture needs exactly four lines");
    end

    logic [LINES-1:0]  pinSync;
    logic [LINES-1:0]  pinPrev_q;
    logic [LINES-1:0]  pinPrev_d;
    logic [1:0]        rstSync_q;
    logic [1:0]        rstSync_d;
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] mode_d;
    logic [LINES-1:0]  pend_q;
    logic [LINES-1:0]  pend_d;
    logic [LINES-1:0]  req_q;
    logic [LINES-1:0]  req_d;
    logic              wake_q;
    logic              wake_d;
    logic [LINES-1:0]  fallEdge;
    logic [LINES-1:0]  levelReq;

    ////////////////////////////////////////////////////////////////////////
    // [RULE1] pin synchroniser
    // the chain runs through reset so the straps reach the mode capture
    sync_chain #(
        .WIDTH  (LINES),
        .STAGES (SYNC_STAGES),
        .INIT   (PIN_IDLE)
    ) u_pinSync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn (modeIntPin_n),
        .syncOut (pinSync)
    );

    ////////////////////////////////////////////////////////////////////////
    // [RULE6] release synchroniser
    // two flops so the core leaves reset on a clean clock edge, giving lock-step start
    always_comb begin
        rstSync_d = {rstSync_q[0], 1'b1};
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rstSync_q <= {2{RUN_RST}};
        end else begin
            rstSync_q <= rstSync_d;
        end
    end

    assign coreRun = rstSync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // [RULE2] mode capture
    // the register tracks the pins until the synchronised release, then freezes
    always_comb begin
        mode_d = coreRun ? mode_q : pinSync[MODE_W-1:0];
    end

    // no reset branch value from pins; pins are only taken by the clocked path
    always_ff @(posedge mclk) begin
        mode_q <= mode_d;
    end

    assign operatingModeReg = mode_q;

    ////////////////////////////////////////////////////////////////////////
    // [RULE3] edge detect and request generation
    // [RULE7] pending edges, set beats service
    always_comb begin
        pinPrev_d = pinSync;
        fallEdge  = pinPrev_q & ~pinSync & {LINES{coreRun}};
        pend_d    = (pend_q & ~serviceAck) | (fallEdge & intCfg.edgeSel & intCfg.enable);
        levelReq  = ~pinSync & {LINES{coreRun}};
        // trigger select is per line; a vector condition would switch every line at once
        req_d     = intCfg.enable & ((intCfg.edgeSel & pend_d) | (~intCfg.edgeSel & levelReq));
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pinPrev_q <= PIN_IDLE;
            pend_q    <= PEND_RST;
            req_q     <= REQ_RST;
        end else begin
            pinPrev_q <= pinPrev_d;
            pend_q    <= pend_d;
            req_q     <= req_d;
        end
    end

    assign intReq = req_q;

    ////////////////////////////////////////////////////////////////////////
    // [RULE4] wait exit
    // registered so a source that meets the clock sees all processors wake together
    always_comb begin
        wake_d = coreInWait & coreRun & (|req_d);
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    assign waitWake = wake_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // all checks but chk_release_delay rest while reset is held

    chk_mode_frozen: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
        coreRun && $past(coreRun) |-> operatingModeReg == $past(operatingModeReg))
        else $error("mode changed after reset release");

    chk_mode_tracks: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
        !coreRun |=> operatingModeReg == $past(pinSync[MODE_W-1:0]))
        else $error("mode not sampled during reset");

    chk_release_delay: assert property (@(posedge mclk) // [RULE6]
        !reset_n ##1 reset_n |-> !coreRun ##1 !coreRun ##1 (coreRun || !reset_n))
        else $error("release not two cycles");

    chk_sync_delay: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE1]
        $past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n)
        |-> pinSync == $past(modeIntPin_n, 2))
        else $error("synchroniser latency wrong");

    chk_level_req: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE3]
        coreRun && intCfg.enable[0] && !intCfg.edgeSel[0] && !pinSync[0] |=> intReq[0])
        else $error("level request missing");

    chk_masked_off: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE3]
        !intCfg.enable[1] |=> !intReq[1])
        else $error("masked line requested");

    chk_edge_hold: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
        pend_q[2] && !serviceAck[2] |=> pend_q[2])
        else $error("pending edge lost");

    chk_edge_set: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
        fallEdge[3] && intCfg.edgeSel[3] && intCfg.enable[3] |=> pend_q[3] && intReq[3])
        else $error("edge not caught");

    chk_wait_wake: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE4]
        coreRun && coreInWait && (|req_d) |=> waitWake)
        else $error("wait not exited");

    // release and run gate
    chk_quiet_reset: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE6]
        !coreRun |-> intReq == REQ_RST && !waitWake)
        else $error("request before release");

    chk_run_stays: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE6]
        coreRun |=> coreRun)
        else $error("run dropped without reset");

    // request generation
    chk_level_mixed: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE3]
        coreRun && intCfg.enable[3] && !intCfg.edgeSel[3] && intCfg.edgeSel[2] && !pinSync[3] |=> intReq[3])
        else $error("level line lost beside edge line");

    chk_level_drop: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE3]
        !intCfg.edgeSel[1] && pinSync[1] |=> !intReq[1])
        else $error("level request without low pin");

    chk_edge_only_fall: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE3]
        intCfg.edgeSel[2] && !pend_q[2] && !fallEdge[2] |=> !intReq[2])
        else $error("edge request without fall");

    // pending edges against service and enable
    chk_ack_clear: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
        serviceAck[2] && !fallEdge[2] |=> !pend_q[2])
        else $error("service did not clear");

    chk_ack_loses: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
        fallEdge[2] && intCfg.edgeSel[2] && intCfg.enable[2] && serviceAck[2] |=> pend_q[2])
        else $error("service beat a new edge");

    chk_edge_masked: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
        fallEdge[0] && !intCfg.enable[0] && !pend_q[0] |=> !pend_q[0])
        else $error("disabled edge kept");

    // wait exit
    chk_wake_quiet: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE4]
        !coreInWait |=> !waitWake)
        else $error("wake outside wait");

endmodule

// file: design/sync_chain.sv
// multi-bit input synchroniser onto mclk
// assumes each bit is independent; no bus coherency is offered
`timescale 1ns/10ps
module sync_chain
    import mode_irq_pkg::*;
#(
    parameter int         WIDTH  = NUM_LINES,
    parameter int         STAGES = SYNC_STAGES,
    parameter logic [3:0] INIT   = PIN_IDLE
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // data
    input  wire logic [WIDTH-1:0]   asyncIn,
    output logic      [WIDTH-1:0]   syncOut
);

    initial begin
        if (STAGES < 2) $error("sync_chain needs at least two stages");
        if (WIDTH > 4) $error("sync_chain init constant is four bits wide");
    end

    logic [STAGES-1:0][WIDTH-1:0] stage_q;
    logic [STAGES-1:0][WIDTH-1:0] stage_d;

    ////////////////////////////////////////////////////////////////////////
    // shift chain; stage 0 feeds only stage 1
    always_comb begin
        stage_d = {stage_q[STAGES-2:0], asyncIn};
    end

    // free-running through reset too, so the straps reach mode capture while reset is held;
    // the false-edge guard after release sits in the edge detector and its run gate instead
    always_ff @(posedge mclk) begin
        stage_q <= stage_d;
    end

    assign syncOut = stage_q[STAGES-1];

    // [RULE1] second flop only takes the first
    chk_chain_shift: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE1]
        syncOut == $past(stage_q[STAGES-2]))
        else $error("synchroniser stage skipped");

endmodule

// file: verif/strap_source.sv
// partner model: board mode straps and external interrupt sources
// assumes the bench sets the wanted raw pin levels; they are launched on the clock
`timescale 1ns/10ps
module strap_source
    import mode_irq_pkg::*;
(
    // clock
    input  wire logic         mclk,
    // wanted levels from the bench, raw (0 = asserted)
    input  wire logic [3:0]   pinLevel,
    // shared pins toward the block
    output logic      [3:0]   modeIntPin_n = PIN_IDLE
);
    ////////////////////////////////////////////////////////////////////////////
    // clock-synchronous assertion
    // launching on mclk keeps lock-step wake-up exact across several cores
    always_ff @(posedge mclk) begin
        modeIntPin_n <= pinLevel;
    end
endmodule

// file: verif/test_mode_latch_ext_irq.sv
// self-checking bench for the mode strap capture and external request front end
// assumes the partner model drives the pins and the bench plays the core side
`timescale 1ns/10ps
module test_mode_latch_ext_irq
    import mode_irq_pkg::*;
;
    logic       mclk = 1'b0, reset_n = 1'b0, coreInWait = 1'b0, waitWake, coreRun;
    logic [3:0] pinLevel = 4'ha, modeIntPin_n, serviceAck = 4'h0, operatingModeReg, intReq;
    int_cfg_s   intCfg = '{enable: 4'h0, edgeSel: 4'h0};
    int         err_count = 0, comparisons = 0, cycles = 0;

    ////////////////////////////////////////////////////////////////////////////
    // clock and a ceiling on run length, far above the roughly 130 cycles needed
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            report_and_stop();
        end
    end

    strap_source src (.mclk(mclk), .pinLevel(pinLevel), .modeIntPin_n(modeIntPin_n));
    mode_latch_ext_irq dut (.mclk(mclk), .reset_n(reset_n), .modeIntPin_n(modeIntPin_n), .intCfg(intCfg),
        .serviceAck(serviceAck), .coreInWait(coreInWait), .operatingModeReg(operatingModeReg),
        .intReq(intReq), .waitWake(waitWake), .coreRun(coreRun));

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers; sampling 1 ns after the edge lets its updates land
    task check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task wait_req(input logic [3:0] m, input logic [3:0] v, input string msg);
        for (int i = 0; i < 10 && (intReq & m) !== v; i++) step(1);
        check((intReq & m) === v, msg);
    endtask

    task report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task test_mode();
        step(10);
        check(coreRun === 1'b0 && intReq === 4'h0, "active during reset");
        @(posedge mclk) reset_n <= 1'b1;
        for (int i = 0; i < 8 && coreRun !== 1'b1; i++) step(1);
        check(operatingModeReg === 4'ha, "strap not captured");
        @(posedge mclk) pinLevel <= 4'h5;
        step(6);
        check(operatingModeReg === 4'ha && intReq === 4'h0, "mode not frozen");
        @(posedge mclk) pinLevel <= PIN_IDLE;
        step(6);
    endtask

    task test_level_mask();
        @(posedge mclk) pinLevel <= 4'h0;
        step(8);
        check(intReq === 4'h0, "masked line requested");
        @(posedge mclk) pinLevel <= PIN_IDLE;
        step(6);
        @(posedge mclk) intCfg <= '{enable: 4'h3, edgeSel: 4'h0};
        step(2);
        @(posedge mclk) pinLevel <= 4'hc;
        wait_req(4'h3, 4'h3, "level request missing");
        check(waitWake === 1'b0, "wake outside wait");
        @(posedge mclk) pinLevel <= PIN_IDLE;
        wait_req(4'h3, 4'h0, "level request stuck");
    endtask

    task test_edge();
        @(posedge mclk) intCfg <= '{enable: 4'hc, edgeSel: 4'hc};
        step(4);
        check(intReq === 4'h0, "edge kept while disabled");
        @(posedge mclk) pinLevel <= 4'h3;
        wait_req(4'hc, 4'hc, "edge request missing");
        @(posedge mclk) pinLevel <= PIN_IDLE;
        step(6);
        check(intReq === 4'hc, "edge not pending");
        @(posedge mclk) serviceAck <= 4'hc;
        @(posedge mclk) serviceAck <= 4'h0;
        wait_req(4'hc, 4'h0, "ack not clearing");
        // the fall reaches the detector three edges after launch; service lands on that same edge
        @(posedge mclk) pinLevel <= 4'h3;
        step(2);
        @(posedge mclk) serviceAck <= 4'hc;
        @(posedge mclk) serviceAck <= 4'h0;
        step(2);
        check(intReq === 4'hc, "edge lost to service");
        @(posedge mclk) pinLevel <= PIN_IDLE;
        step(4);
        @(posedge mclk) serviceAck <= 4'hc;
        @(posedge mclk) serviceAck <= 4'h0;
        wait_req(4'hc, 4'h0, "second ack not clearing");
    endtask

    task test_wake();
        @(posedge mclk) intCfg <= '{enable: 4'hc, edgeSel: 4'h4};
        coreInWait <= 1'b1;
        step(4);
        check(waitWake === 1'b0, "wake with no request");
        @(posedge mclk) pinLevel <= 4'h7;
        for (int i = 0; i < 10 && waitWake !== 1'b1; i++) step(1);
        check(waitWake === 1'b1, "wait not ended");
        check(intReq === 4'h8, "mixed trigger lines");
        @(posedge mclk) pinLevel <= PIN_IDLE;
        coreInWait <= 1'b0;
        step(6);
        check(waitWake === 1'b0 && intReq === 4'h0, "wake after request gone");
    endtask

    task test_rereset();
        @(posedge mclk) reset_n <= 1'b0;
        pinLevel <= 4'h5;
        intCfg <= '{enable: 4'h0, edgeSel: 4'h0};
        step(10);
        check(coreRun === 1'b0 && intReq === 4'h0 && waitWake === 1'b0, "active during second reset");
        @(posedge mclk) reset_n <= 1'b1;
        step(1);
        check(coreRun === 1'b0, "release not synchronised");
        step(1);
        check(coreRun === 1'b1 && operatingModeReg === 4'h5, "second strap not captured");
        @(posedge mclk) pinLevel <= PIN_IDLE;
        step(6);
        check(operatingModeReg === 4'h5, "second mode not frozen");
    endtask

    initial begin
        test_mode();
        test_level_mask();
        test_edge();
        test_wake();
        test_rereset();
        report_and_stop();
    end
endmodule
